// ==== include/rfs_defines.svh ====
// Timing and encoding constants for the regulator fault sequencer.
`ifndef RFS_DEFINES_SVH
`define RFS_DEFINES_SVH

`define RFS_CLK_MHZ    25
`define RFS_CLK_KHZ    25000
`define RFS_SW_KHZ     800
`define RFS_NUM_CH     4
`define RFS_NUM_BUCK   3
`define RFS_LIN_CH     3
`define RFS_SS_BUCK_US 3500
`define RFS_SS_LIN_US  500
`define RFS_OC_US      10000
`define RFS_RETRY_US   100000
`define RFS_PG_US      100
`define RFS_GLITCH_US  10
`define RFS_TMR_W      22
`define RFS_PG_W       12
`define RFS_FILT_W     9
`define RFS_PH_W       18

`endif

// ==== include/rfs_pkg.sv ====
// Shared types of the regulator fault sequencer.
`default_nettype none
package rfs_pkg;

  // Channel sequencing states, one-hot.
  typedef enum logic [5:0] {
    RFS_ST_STBY = 6'h01,
    RFS_ST_SOFT = 6'h02,
    RFS_ST_RUN  = 6'h04,
    RFS_ST_OCL  = 6'h08,
    RFS_ST_WAIT = 6'h10,
    RFS_ST_HOT  = 6'h20
  } rfs_state_e;

  // Reported operating mode of one channel.
  typedef enum logic [1:0] {
    RFS_MODE_STANDBY = 2'h0,
    RFS_MODE_NORMAL  = 2'h1,
    RFS_MODE_FAULT   = 2'h2
  } rfs_mode_e;

  // Command to the analog loop of one channel.
  typedef enum logic [1:0] {
    RFS_ACT_REGULATE = 2'h0,
    RFS_ACT_LOW      = 2'h1,
    RFS_ACT_HIGH     = 2'h2,
    RFS_ACT_OFF      = 2'h3
  } rfs_action_e;

endpackage : rfs_pkg
`default_nettype wire

// ==== rtl/rfs_glitch_filter.sv ====
// Comparator synchroniser with a qualifying glitch filter.
`timescale 1ns/100ps
`default_nettype none
module rfs_glitch_filter #(
  parameter int FILT_CYC = 250,
  parameter int CW       = 9
) (
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic raw_in,
  output logic      level_out,
  output logic      filt_out
);
  logic          meta_ff;
  logic          sync_ff;
  logic [CW-1:0] cnt_ff;
  logic          filt_ff;
  logic          done_w;

  // The counter saturates so a long fault never wraps back to clear.
  assign done_w    = (cnt_ff == CW'(FILT_CYC - 1));
  assign level_out = sync_ff;
  assign filt_out  = filt_ff;

  // Two flops isolate the analog comparator from the logic.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
    end
  end

  // Fault is reported only after it persists; release is immediate.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || !sync_ff) begin
      cnt_ff  <= '0;
      filt_ff <= 1'b0;
    end else begin
      if (!done_w) cnt_ff <= cnt_ff + 1'b1;
      if (done_w) filt_ff <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  a_filter_release: assert property (!sync_ff |=> !filt_ff)
    else $error("filter output outlived its input");
  a_filter_short: assert property (filt_ff |-> $past(sync_ff, 2))
    else $error("filter passed a short glitch");
endmodule : rfs_glitch_filter
`default_nettype wire

// ==== rtl/rfs_channel.sv ====
// Per-channel sequencer: soft start, current-limit timing, retry and thermal recovery.
`timescale 1ns/100ps
`default_nettype none
module rfs_channel #(
  parameter int SS_CYC    = 87500,
  parameter int OC_CYC    = 250000,
  parameter int RETRY_CYC = 2500000,
  parameter bit HAS_OCP   = 1'b1,
  parameter int TW        = 22
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  input  wire logic              en_in,
  input  wire logic              ov_f_in,
  input  wire logic              uv_f_in,
  input  wire logic              ilim_in,
  input  wire logic              ilim_f_in,
  input  wire logic              short_in,
  input  wire logic              hot_in,
  output logic                   on_out,
  output logic                   ss_out,
  output logic                   ok_out,
  output rfs_pkg::rfs_mode_e     mode_out,
  output rfs_pkg::rfs_action_e   action_out
);
  import rfs_pkg::*;

  rfs_state_e    state_ff, nxt_state;
  logic [TW-1:0] tmr_ff, nxt_tmr;
  logic          ilim_w, short_w, ss_end_w, oc_end_w, retry_end_w, fault_w;

  // Limit inputs are ignored on a channel without a current sensor.
  assign ilim_w      = HAS_OCP && ilim_in;
  assign short_w     = HAS_OCP && short_in;
  assign ss_end_w    = (tmr_ff == TW'(SS_CYC - 1));
  assign oc_end_w    = (tmr_ff == TW'(OC_CYC - 1));
  assign retry_end_w = (tmr_ff == TW'(RETRY_CYC - 1));

  // Next state; a low enable wins over everything, then heat, then a hard short.
  always_comb begin
    nxt_state = state_ff;
    nxt_tmr   = tmr_ff + 1'b1;
    if (!en_in) begin
      nxt_state = RFS_ST_STBY;
      nxt_tmr   = '0;
    end else if (hot_in && state_ff != RFS_ST_HOT && state_ff != RFS_ST_WAIT) begin
      nxt_state = RFS_ST_HOT;
      nxt_tmr   = '0;
    end else begin
      unique case (state_ff)
        RFS_ST_STBY: begin
          nxt_state = RFS_ST_SOFT;
          nxt_tmr   = '0;
        end
        RFS_ST_SOFT, RFS_ST_RUN: begin
          if (short_w) begin
            nxt_state = RFS_ST_WAIT;
            nxt_tmr   = '0;
          end else if (ilim_w) begin
            nxt_state = RFS_ST_OCL;
            nxt_tmr   = '0;
          end else if (state_ff == RFS_ST_SOFT && ss_end_w) begin
            nxt_state = RFS_ST_RUN;
          end
        end
        RFS_ST_OCL: begin
          if (short_w || oc_end_w) begin
            nxt_state = RFS_ST_WAIT;
            nxt_tmr   = '0;
          end else if (!ilim_w) begin
            nxt_state = RFS_ST_RUN;
          end
        end
        RFS_ST_WAIT: begin
          if (retry_end_w) begin
            nxt_state = hot_in ? RFS_ST_HOT : RFS_ST_SOFT;
            nxt_tmr   = '0;
          end
        end
        RFS_ST_HOT: begin
          if (!hot_in) begin
            nxt_state = RFS_ST_SOFT;
          end
          nxt_tmr = '0;
        end
        default: begin
          nxt_state = RFS_ST_STBY;
          nxt_tmr   = '0;
        end
      endcase
    end
  end

  // State and the single shared timer; states never need two timers at once.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_ff <= RFS_ST_STBY;
      tmr_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff   <= nxt_tmr;
    end
  end

  // Under-voltage is expected while ramping, so it is not a fault then.
  assign fault_w = (state_ff == RFS_ST_HOT) || (state_ff == RFS_ST_WAIT)
                 || (state_ff == RFS_ST_OCL && ilim_f_in) || ov_f_in
                 || (uv_f_in && state_ff != RFS_ST_SOFT);
  assign on_out  = (state_ff == RFS_ST_SOFT) || (state_ff == RFS_ST_RUN)
                 || (state_ff == RFS_ST_OCL);
  assign ss_out  = (state_ff == RFS_ST_SOFT);
  assign ok_out  = on_out && !ss_out && !fault_w;
  assign mode_out = (state_ff == RFS_ST_STBY) ? RFS_MODE_STANDBY
                  : fault_w ? RFS_MODE_FAULT : RFS_MODE_NORMAL;
  // Voltage faults steer the loop but keep the channel regulating.
  assign action_out = !on_out ? RFS_ACT_OFF
                    : ov_f_in ? RFS_ACT_LOW
                    : (uv_f_in && !ss_out) ? RFS_ACT_HIGH
                    : RFS_ACT_REGULATE;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence s_oc_expire;
    state_ff == RFS_ST_OCL && oc_end_w && en_in && !hot_in && !short_w;
  endsequence
  sequence s_retry_done;
    state_ff == RFS_ST_WAIT && retry_end_w && en_in && !hot_in;
  endsequence

  a_standby_low_en: assert property (!en_in |=> state_ff == RFS_ST_STBY)
    else $error("disabled channel left standby");
  a_enable_ramps: assert property (state_ff == RFS_ST_STBY && en_in && !hot_in
                                   |=> state_ff == RFS_ST_SOFT ##1 tmr_ff == TW'(1))
    else $error("enable did not start a fresh soft start");
  a_ramp_length: assert property (state_ff == RFS_ST_SOFT |-> tmr_ff < TW'(SS_CYC))
    else $error("soft start overran its length");
  a_oc_expire: assert property (s_oc_expire |=> state_ff == RFS_ST_WAIT && !on_out)
    else $error("overcurrent expiry did not turn the channel off");
  a_retry_soft: assert property (s_retry_done |=> state_ff == RFS_ST_SOFT)
    else $error("restart wait did not lead to soft start");
  a_short_off: assert property (on_out && en_in && !hot_in && short_w
                                |=> state_ff == RFS_ST_WAIT && tmr_ff == '0)
    else $error("hard short did not stop the channel");
  a_thermal_off: assert property (en_in && hot_in |=> !on_out)
    else $error("hot channel kept running");
  a_oc_recover: assert property (state_ff == RFS_ST_OCL && en_in && !hot_in && !short_w
                                 && !ilim_w && !oc_end_w |=> state_ff == RFS_ST_RUN)
    else $error("channel did not recover from current limit");
endmodule : rfs_channel
`default_nettype wire

// ==== rtl/rfs_top.sv ====
// Top level of the quad regulator fault sequencer.
//
// Summary of operation
// - Hold all channels in reset until the gate-drive rail reaches about 4.0 V.
// - Each of the four channels has its own enable, in any order.
// - Enables are active high; control logic runs whenever supply is present.
// - Soft start lasts 3.5 ms on bucks and 0.5 ms on the linear channel.
// - Fresh soft start on every enable, every retry and every supply cycle.
// - Release power good 100 us after all channels run fault-free.
// - Power good is true only while every channel is normal, else low.
// - A low enable puts its channel in quiet standby with no fault.
// - An enabled channel is in fault mode on regulation, current or heat trouble.
// - Output-high fault: drop power good, keep regulating with minimum drive.
// - Output-high detection passes a 10 us filter; clears once back in regulation.
// - Output-low fault: drop power good, keep regulating with maximum drive.
// - Output-low detection uses the same filter and clears on return.
// - Current trip starts limiting, filtered power-good drop and a 10 ms timer.
// - Current back to normal before timeout resumes normal operation.
// - Timer expiry turns the channel off for 100 ms, then soft start.
// - A hard short stops the channel at once, then the same restart wait.
// - Thermal trip switches the channel off; soft start after cooling.
// - Switching clocks run at 800 kHz, spaced 120 degrees apart.
`timescale 1ns/100ps
`default_nettype none
`include "rfs_defines.svh"
module rfs_top #(
  parameter int SS_BUCK_CYC = `RFS_SS_BUCK_US * `RFS_CLK_MHZ,
  parameter int SS_LIN_CYC  = `RFS_SS_LIN_US * `RFS_CLK_MHZ,
  parameter int OC_CYC      = `RFS_OC_US * `RFS_CLK_MHZ,
  parameter int RETRY_CYC   = `RFS_RETRY_US * `RFS_CLK_MHZ
) (
  input  wire logic                           clk_sys_in,
  input  wire logic                           sys_rst_in,
  input  wire logic                           gate_drive_rail_ok_in,
  input  wire logic                           buck_one_on_in,
  input  wire logic                           buck_two_on_in,
  input  wire logic                           buck_three_on_in,
  input  wire logic                           linear_channel_on_in,
  input  wire logic [`RFS_NUM_CH-1:0]         output_high_fault_in,
  input  wire logic [`RFS_NUM_CH-1:0]         output_low_fault_in,
  input  wire logic [`RFS_NUM_CH-1:0]         thermal_trip_in,
  input  wire logic [`RFS_NUM_BUCK-1:0]       current_limit_in,
  input  wire logic [`RFS_NUM_BUCK-1:0]       hard_short_in,
  output logic                                por_active_out,
  output logic [`RFS_NUM_CH-1:0]              ch_power_on_out,
  output logic [`RFS_NUM_CH-1:0]              soft_start_out,
  output rfs_pkg::rfs_mode_e   [`RFS_NUM_CH-1:0] ch_mode_out,
  output rfs_pkg::rfs_action_e [`RFS_NUM_CH-1:0] ch_action_out,
  output logic [`RFS_NUM_BUCK-1:0]            sw_phase_out,
  output logic                                supply_ok_flag_out,
  output logic                                supply_ok_flag_oe_out
);
  import rfs_pkg::*;

  localparam int PG_CYC     = `RFS_PG_US * `RFS_CLK_MHZ;
  localparam int GLITCH_CYC = `RFS_GLITCH_US * `RFS_CLK_MHZ;
  localparam int PH_MOD     = 3 * `RFS_CLK_KHZ;
  localparam int PH_STEP    = 3 * `RFS_SW_KHZ;

  // Phase accumulator output for one buck, each a third of a period behind the one before.
  // Adding the full modulus first keeps the sum positive, so one wrap step is enough.
  function automatic logic phase_high(input logic [`RFS_PH_W-1:0] acc, input int idx);
    logic [`RFS_PH_W-1:0] s;
    s = acc + `RFS_PH_W'(PH_MOD - idx * `RFS_CLK_KHZ);
    if (s >= `RFS_PH_W'(PH_MOD)) s = s - `RFS_PH_W'(PH_MOD);
    return s < `RFS_PH_W'(PH_MOD / 2);
  endfunction : phase_high

  logic [`RFS_NUM_CH-1:0]   en_raw_w;
  logic                     rail_meta_ff, rail_sync_ff;
  logic [`RFS_NUM_CH-1:0]   en_meta_ff, en_sync_ff;
  logic [`RFS_NUM_CH-1:0]   hot_meta_ff, hot_sync_ff;
  logic [`RFS_NUM_BUCK-1:0] short_meta_ff, short_sync_ff;
  logic                     por_ff;
  logic                     ch_rst_w;

  assign en_raw_w = {linear_channel_on_in, buck_three_on_in,
                     buck_two_on_in, buck_one_on_in};

  // Every pin from outside other than sys_rst_in passes two flops before any logic reads it.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rail_meta_ff  <= 1'b0;
      rail_sync_ff  <= 1'b0;
      en_meta_ff    <= '0;
      en_sync_ff    <= '0;
      hot_meta_ff   <= '0;
      hot_sync_ff   <= '0;
      short_meta_ff <= '0;
      short_sync_ff <= '0;
    end else begin
      rail_meta_ff  <= gate_drive_rail_ok_in;
      rail_sync_ff  <= rail_meta_ff;
      en_meta_ff    <= en_raw_w;
      en_sync_ff    <= en_meta_ff;
      hot_meta_ff   <= thermal_trip_in;
      hot_sync_ff   <= hot_meta_ff;
      short_meta_ff <= hard_short_in;
      short_sync_ff <= short_meta_ff;
    end
  end

  // Internal reset holds while the gate-drive rail is low, and again if it sags.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) por_ff <= 1'b1;
    else            por_ff <= !rail_sync_ff;
  end
  assign ch_rst_w = sys_rst_in || por_ff;

  logic [`RFS_NUM_CH-1:0] ov_f_w, uv_f_w, ilim_w, ilim_f_w, short_w;
  logic [`RFS_NUM_CH-1:0] on_w, ss_w, ok_w;
  rfs_mode_e   [`RFS_NUM_CH-1:0] mode_w;
  rfs_action_e [`RFS_NUM_CH-1:0] action_w;

  // One set of filters and timers per channel; the linear one has no current sensor.
  for (genvar ch = 0; ch < `RFS_NUM_CH; ch++) begin : g_ch
    localparam bit IS_BUCK = (ch != `RFS_LIN_CH);
    logic ilim_raw_w;
    assign ilim_raw_w = IS_BUCK ? current_limit_in[ch % `RFS_NUM_BUCK] : 1'b0;
    assign short_w[ch] = IS_BUCK ? short_sync_ff[ch % `RFS_NUM_BUCK] : 1'b0;

    rfs_glitch_filter #(.FILT_CYC(GLITCH_CYC), .CW(`RFS_FILT_W)) u_ov_filt (
      .clk_sys_in (clk_sys_in),
      .sys_rst_in (ch_rst_w),
      .raw_in     (output_high_fault_in[ch]),
      .level_out  (),
      .filt_out   (ov_f_w[ch])
    );
    rfs_glitch_filter #(.FILT_CYC(GLITCH_CYC), .CW(`RFS_FILT_W)) u_uv_filt (
      .clk_sys_in (clk_sys_in),
      .sys_rst_in (ch_rst_w),
      .raw_in     (output_low_fault_in[ch]),
      .level_out  (),
      .filt_out   (uv_f_w[ch])
    );
    rfs_glitch_filter #(.FILT_CYC(GLITCH_CYC), .CW(`RFS_FILT_W)) u_il_filt (
      .clk_sys_in (clk_sys_in),
      .sys_rst_in (ch_rst_w),
      .raw_in     (ilim_raw_w),
      .level_out  (ilim_w[ch]),
      .filt_out   (ilim_f_w[ch])
    );
    rfs_channel #(
      .SS_CYC    (IS_BUCK ? SS_BUCK_CYC : SS_LIN_CYC),
      .OC_CYC    (OC_CYC),
      .RETRY_CYC (RETRY_CYC),
      .HAS_OCP   (IS_BUCK),
      .TW        (`RFS_TMR_W)
    ) u_chan (
      .clk_sys_in (clk_sys_in),
      .rst_in     (ch_rst_w),
      .en_in      (en_sync_ff[ch]),
      .ov_f_in    (ov_f_w[ch]),
      .uv_f_in    (uv_f_w[ch]),
      .ilim_in    (ilim_w[ch]),
      .ilim_f_in  (ilim_f_w[ch]),
      .short_in   (short_w[ch]),
      .hot_in     (hot_sync_ff[ch]),
      .on_out     (on_w[ch]),
      .ss_out     (ss_w[ch]),
      .ok_out     (ok_w[ch]),
      .mode_out   (mode_w[ch]),
      .action_out (action_w[ch])
    );
  end

  // Power good needs every channel enabled and in regulation, then a settle delay.
  logic                  all_ok_w, pg_done_w;
  logic [`RFS_PG_W-1:0]  pg_cnt_ff;
  logic                  pg_rel_ff;
  assign all_ok_w  = !por_ff && (&en_sync_ff) && (&ok_w);
  assign pg_done_w = (pg_cnt_ff == `RFS_PG_W'(PG_CYC - 1));

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || !all_ok_w) begin
      pg_cnt_ff <= '0;
      pg_rel_ff <= 1'b0;
    end else begin
      if (!pg_done_w) pg_cnt_ff <= pg_cnt_ff + 1'b1;
      if (pg_done_w) pg_rel_ff <= 1'b1;
    end
  end

  // Fractional accumulator gives an exact 800 kHz average from the 25 MHz clock.
  logic [`RFS_PH_W-1:0]     ph_acc_ff;
  logic [`RFS_PH_W-1:0]     ph_sum_w;
  logic [`RFS_NUM_BUCK-1:0] ph_w;
  assign ph_sum_w = ph_acc_ff + `RFS_PH_W'(PH_STEP);
  for (genvar b = 0; b < `RFS_NUM_BUCK; b++) begin : g_ph
    assign ph_w[b] = phase_high(ph_acc_ff, b);
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) ph_acc_ff <= '0;
    else if (ph_sum_w >= `RFS_PH_W'(PH_MOD)) ph_acc_ff <= ph_sum_w - `RFS_PH_W'(PH_MOD);
    else ph_acc_ff <= ph_sum_w;
  end

  // Outputs are registered copies so no comparator glitch reaches a pin.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      por_active_out        <= 1'b1;
      ch_power_on_out       <= '0;
      soft_start_out        <= '0;
      ch_mode_out           <= '{default: RFS_MODE_STANDBY};
      ch_action_out         <= '{default: RFS_ACT_OFF};
      sw_phase_out          <= '0;
      supply_ok_flag_out    <= 1'b0;
      supply_ok_flag_oe_out <= 1'b1;
    end else begin
      por_active_out        <= por_ff;
      ch_power_on_out       <= on_w;
      soft_start_out        <= ss_w;
      ch_mode_out           <= mode_w;
      ch_action_out         <= action_w;
      sw_phase_out          <= ph_w & on_w[`RFS_NUM_BUCK-1:0];
      supply_ok_flag_out    <= 1'b0;
      supply_ok_flag_oe_out <= !pg_rel_ff;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  // A fresh run of good cycles right after a drop; the delay counter starts from zero there.
  sequence s_all_ok_run;
    !all_ok_w ##1 all_ok_w [*8];
  endsequence

  a_por_holds: assert property (!rail_sync_ff |=> por_ff ##2 ch_power_on_out == '0)
    else $error("channels ran before the gate-drive rail was up");
  a_pg_low_fault: assert property (!all_ok_w |=> ##1 supply_ok_flag_oe_out)
    else $error("power good released with a channel not ok");
  a_pg_not_early: assert property (s_all_ok_run |-> !pg_rel_ff)
    else $error("power good released before its delay");
  a_pg_on_time: assert property (all_ok_w && pg_done_w |=> pg_rel_ff ##1 !supply_ok_flag_oe_out)
    else $error("power good not released at the end of its delay");
  a_phase_period: assert property ($rose(ph_w[0]) |-> ##[31:32] $rose(ph_w[0]))
    else $error("switching phase period is wrong");
  a_phase_spacing: assert property ($rose(ph_w[0]) |-> ##[10:11] $rose(ph_w[1]))
    else $error("second switching phase is not a third behind");
endmodule : rfs_top
`default_nettype wire

// ==== include/rfs_pkg_note_unused.sv ====
// Intentionally empty compile unit.
`default_nettype none
`default_nettype wire

// ==== tb/rfs_host_model.sv ====
// Host-side partner: drives the four channel enables and reads the power-good line.
`timescale 1ns/100ps
`default_nettype none
module rfs_host_model (
  input  wire logic       clk_sys_in,
  input  wire logic [3:0] en_req_in,
  input  wire logic       pg_data_in,
  input  wire logic       pg_oe_in,
  output var  logic [3:0] en_out,
  output logic            pg_line_out
);
  // Enables start low so the device never sees an unknown level.
  initial begin
    en_out = 4'h0;
  end

  // Each enable is a level that changes just after an edge, in any order.
  always @(posedge clk_sys_in) begin
    en_out <= en_req_in;
  end

  // The board pull-up lifts the line whenever the device lets go of it.
  assign pg_line_out = pg_oe_in ? pg_data_in : 1'b1;
endmodule : rfs_host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking testbench of the regulator fault sequencer.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import rfs_pkg::*;
  typedef struct { int ch; int ss_len; } rfs_row_s;
  logic              clk_sys_in = 1'b0;
  logic              sys_rst_in = 1'b1;
  logic              rail       = 1'b0;
  logic [3:0]        req        = 4'h0;
  logic [3:0]        ov         = 4'h0;
  logic [3:0]        uv         = 4'h0;
  logic [3:0]        hot        = 4'h0;
  logic [2:0]        ilim       = 3'h0;
  logic [2:0]        shrt       = 3'h0;
  logic [3:0]        en;
  logic [3:0]        pwr;
  logic [3:0]        ss;
  logic [2:0]        ph;
  rfs_mode_e   [3:0] mode;
  rfs_action_e [3:0] act;
  logic              por;
  logic              pg_d;
  logic              pg_oe;
  logic              pg_line;
  int                fail_count = 0;
  int                tests_run  = 0;
  int                n;
  int                hi [3];
  // Single-channel cases: channel and its soft-start length in cycles.
  rfs_row_s rows [4] = '{'{0, 40}, '{1, 40}, '{2, 40}, '{3, 20}};

  // Short timer values keep the run brief; expectations use the same figures.
  rfs_top #(.SS_BUCK_CYC(40), .SS_LIN_CYC(20), .OC_CYC(60), .RETRY_CYC(100)) dut_u (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .gate_drive_rail_ok_in(rail),
    .buck_one_on_in(en[0]), .buck_two_on_in(en[1]), .buck_three_on_in(en[2]),
    .linear_channel_on_in(en[3]), .output_high_fault_in(ov), .output_low_fault_in(uv),
    .thermal_trip_in(hot), .current_limit_in(ilim), .hard_short_in(shrt),
    .por_active_out(por), .ch_power_on_out(pwr), .soft_start_out(ss),
    .ch_mode_out(mode), .ch_action_out(act), .sw_phase_out(ph),
    .supply_ok_flag_out(pg_d), .supply_ok_flag_oe_out(pg_oe));

  rfs_host_model host_u (
    .clk_sys_in(clk_sys_in), .en_req_in(req), .pg_data_in(pg_d),
    .pg_oe_in(pg_oe), .en_out(en), .pg_line_out(pg_line));

  // Free-running 25 MHz clock.
  always #20 clk_sys_in = ~clk_sys_in;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Moves past k edges and samples once the edge's updates have landed.
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_in);
    #1;
  endtask : tick

  // Bounded wait on one condition; a wait that runs out counts as a mismatch.
  task automatic wait_until(input int kind, input int ch, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit && cnt < lim) begin
      tick(1);
      cnt++;
      case (kind)
        0: hit = (pwr[ch] === 1'b1);
        1: hit = (pwr[ch] === 1'b0);
        2: hit = (ss[ch] === 1'b1);
        3: hit = (ss[ch] === 1'b0);
        default: hit = (pg_oe === 1'b0);
      endcase
    end
    check(hit, 1'b1);
  endtask : wait_until

  // Regulation fault that must pass the glitch filter, then clear at once.
  task automatic reg_fault(input int ch, input bit high);
    @(posedge clk_sys_in);
    if (high) ov[ch] <= 1'b1;
    else uv[ch] <= 1'b1;
    tick(245);
    check(mode[ch], RFS_MODE_NORMAL);
    tick(15);
    check(mode[ch], RFS_MODE_FAULT);
    check(act[ch], high ? RFS_ACT_LOW : RFS_ACT_HIGH);
    check({pwr[ch], pg_oe, pg_line}, 3'h6);
    @(posedge clk_sys_in);
    ov[ch] <= 1'b0;
    uv[ch] <= 1'b0;
    tick(6);
    check({mode[ch], act[ch]}, {RFS_MODE_NORMAL, RFS_ACT_REGULATE});
  endtask : reg_fault

  task automatic complete_run;
    $display("TB: %0d checks, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // Watchdog sized well above the roughly 4000 cycles the sequence needs.
  initial begin
    #1000000;
    fail_count++;
    complete_run();
  end

  // Main sequence: table of single channels, then the awkward cases.
  initial begin
    tick(1);
    check({por, pg_oe, pwr}, 6'h30);
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    tick(10);
    check(por, 1'b1);
    @(posedge clk_sys_in);
    rail <= 1'b1;
    tick(6);
    check(por, 1'b0);
    foreach (rows[i]) begin
      @(posedge clk_sys_in);
      req[rows[i].ch] <= 1'b1;
      wait_until(0, rows[i].ch, 12, n);
      wait_until(3, rows[i].ch, 60, n);
      check(n >= rows[i].ss_len - 1 && n <= rows[i].ss_len + 2, 1'b1);
      check({mode[rows[i].ch], pg_oe}, {RFS_MODE_NORMAL, 1'b1});
      @(posedge clk_sys_in);
      req[rows[i].ch] <= 1'b0;
      wait_until(1, rows[i].ch, 12, n);
      check({mode[rows[i].ch], act[rows[i].ch]}, {RFS_MODE_STANDBY, RFS_ACT_OFF});
    end
    // All channels on: power good is released one delay after the last run.
    @(posedge clk_sys_in);
    req <= 4'hf;
    wait_until(0, 0, 12, n);
    wait_until(3, 0, 60, n);
    wait_until(4, 0, 3000, n);
    check(n >= 2490 && n <= 2510, 1'b1);
    check(pg_line, 1'b1);
    reg_fault(0, 1'b1);
    reg_fault(1, 1'b0);
    // A brief current trip recovers without leaving normal mode.
    @(posedge clk_sys_in);
    ilim[2] <= 1'b1;
    repeat (30) @(posedge clk_sys_in);
    ilim[2] <= 1'b0;
    tick(10);
    check({pwr[2], mode[2]}, {1'b1, RFS_MODE_NORMAL});
    // A lasting trip times out, waits, then retries with soft start.
    @(posedge clk_sys_in);
    ilim[2] <= 1'b1;
    wait_until(1, 2, 100, n);
    check(n >= 60 && n <= 70, 1'b1);
    @(posedge clk_sys_in);
    ilim[2] <= 1'b0;
    wait_until(2, 2, 150, n);
    check(n >= 95 && n <= 105, 1'b1);
    // A hard short stops the channel at once, then the same wait.
    @(posedge clk_sys_in);
    shrt[0] <= 1'b1;
    wait_until(1, 0, 8, n);
    @(posedge clk_sys_in);
    shrt[0] <= 1'b0;
    wait_until(2, 0, 150, n);
    check(n >= 95 && n <= 105, 1'b1);
    // Thermal trip holds the channel off until it cools.
    @(posedge clk_sys_in);
    hot[3] <= 1'b1;
    wait_until(1, 3, 8, n);
    tick(20);
    check({pwr[3], mode[3], pg_oe}, {1'b0, RFS_MODE_FAULT, 1'b1});
    @(posedge clk_sys_in);
    hot[3] <= 1'b0;
    wait_until(2, 3, 10, n);
    // Each running buck clock is high half the time; 125 cycles hold four whole periods.
    hi = '{0, 0, 0};
    repeat (125) begin
      tick(1);
      foreach (hi[b]) hi[b] += ph[b];
    end
    foreach (hi[b]) check(hi[b] >= 62 && hi[b] <= 63, 1'b1);
    // Losing the gate-drive rail re-enters internal reset and stops the switching clocks.
    @(posedge clk_sys_in);
    rail <= 1'b0;
    tick(6);
    check({por, pwr, ph}, 8'h80);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
